// File: smd_params.svh
`ifndef SMD_PARAMS_SVH
`define SMD_PARAMS_SVH

// register port geometry
`define SMD_ADDR_W 8
`define SMD_DATA_W 32

// register byte offsets
`define SMD_OFS_CTRL 8'h00
`define SMD_OFS_POS_START 8'h04
`define SMD_OFS_POS_END 8'h08
`define SMD_OFS_POS_MID 8'h0c
`define SMD_OFS_PROF_START 8'h10
`define SMD_OFS_PROF_END 8'h14
`define SMD_OFS_PROF_MID 8'h18
`define SMD_OFS_BAND 8'h1c
`define SMD_OFS_STATUS 8'h20

// control word fields
`define SMD_CTRL_PAT_LSB 0
`define SMD_CTRL_PAT_MSB 1
`define SMD_CTRL_LOCK_BIT 8

// move profile word fields
`define SMD_PROF_SPD_LSB 0
`define SMD_PROF_SPD_MSB 15
`define SMD_PROF_ACC_LSB 16
`define SMD_PROF_ACC_MSB 23
`define SMD_PROF_PUSH_BIT 24

// status word fields
`define SMD_STAT_ST0_BIT 0
`define SMD_STAT_ST1_BIT 1
`define SMD_STAT_HOLD_BIT 2
`define SMD_STAT_HALT_BIT 3
`define SMD_STAT_REQ_BIT 4
`define SMD_STAT_DST_LSB 5
`define SMD_STAT_DST_MSB 6
`define SMD_STAT_DET_LSB 7
`define SMD_STAT_DET_MSB 9
`define SMD_STAT_RUN_BIT 10

// reset values
`define SMD_RST_PROF 32'h0000_0000
`define SMD_RST_BAND 16'h0004

// operation pattern codes
`define SMD_CODE_SINGLE 2'h0
`define SMD_CODE_DOUBLE 2'h1
`define SMD_CODE_MID_ON 2'h2
`define SMD_CODE_MID_OFF 2'h3

// pin filter: idle levels of {hold_n, second, first}
`define SMD_PIN_RST 3'h4

`endif

// File: smd_pkg.sv
`include "smd_params.svh"

package smd_pkg;

    // operation pattern, fixed at configuration time
    typedef enum logic [1:0] {
        PAT_SINGLE = `SMD_CODE_SINGLE,
        PAT_DOUBLE = `SMD_CODE_DOUBLE,
        PAT_MID_ON = `SMD_CODE_MID_ON,
        PAT_MID_OFF = `SMD_CODE_MID_OFF
    } smd_pat_t;

    // block state, one-hot
    typedef enum logic [1:0] {
        ST_CFG = 2'b01,
        ST_RUN = 2'b10
    } smd_state_t;

    // commanded destination
    typedef enum logic [1:0] {
        DST_NONE = 2'h0,
        DST_START = 2'h1,
        DST_END = 2'h2,
        DST_MID = 2'h3
    } smd_dst_t;

endpackage : smd_pkg

// File: smd_pin_if.sv
`timescale 1ns/1ns
`default_nettype none

// raw pin levels in, filtered levels out
interface smd_pin_if #(parameter int N = 3);
    logic [N-1:0] raw;
    logic [N-1:0] clean;
    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface : smd_pin_if

`default_nettype wire

// File: smd_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module smd_pin_sync #(
    parameter int N = 3,
    parameter logic [N-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    smd_pin_if.filt pins
);
    logic [N-1:0] s1_reg;
    logic [N-1:0] s2_reg;
    logic [N-1:0] s3_reg;
    logic [N-1:0] clean_reg;
    logic [N-1:0] clean_next;
    wire [N-1:0] agree;

    // a level counts once stages two and three agree; s1 feeds s2 only
    assign agree = ~(s2_reg ^ s3_reg);
    assign clean_next = (agree & s3_reg) | (~agree & clean_reg);
    assign pins.clean = clean_reg;

    // three-stage chain plus filtered level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            clean_reg <= RST_VAL;
        end else begin
            s1_reg <= pins.raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            clean_reg <= clean_next;
        end
    end

    property p_sync_agree;
        @(posedge clk) disable iff (!rst_n)
        (s2_reg == s3_reg) |=> (pins.clean == $past(s3_reg));
    endproperty
    a_sync_agree: assert property (p_sync_agree) else $error("filtered level missed agreement");

    property p_sync_hold;
        @(posedge clk) disable iff (!rst_n)
        (s2_reg != s3_reg) |=> $stable(pins.clean);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("filtered level moved on a glitch");

endmodule : smd_pin_sync

`default_nettype wire

// File: smd_top.sv
//
// Overview of operation
// [R01] single mode: first input ON moves to end
// [R02] single mode: first input OFF returns to start
// [R03] double mode: second input turning ON goes end
// [R04] double mode: first input turning ON goes start
// [R05] both-ON variant: both ON positions to middle
// [R06] both-ON variant: both OFF halts in place
// [R07] both-OFF variant: both OFF positions to middle
// [R08] both-OFF variant: both ON halts in place
// [R09] separate start and end targets held
// [R10] separate intermediate target held
// [R11] each move carries speed, acceleration, push option
// [R12] pattern fixed once configuration is locked
// [R13] active-low output idles high; low input acts
// [R14] detect outputs follow actuator at each target
// [R15] controller holds move inputs steady during moves
//
`timescale 1ns/1ns
`default_nettype none

`include "smd_params.svh"

module smd_top #(
    parameter int POS_W = 16
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // register port
    input wire logic [`SMD_ADDR_W-1:0] REG_ADDR,
    input wire logic [`SMD_DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [`SMD_DATA_W-1:0] REG_RDATA,
    // move inputs from the controller pins
    input wire logic MOVE_CMD_FIRST,
    input wire logic MOVE_CMD_SECOND,
    input wire logic HOLD_N,
    // motion generator side
    input wire logic [POS_W-1:0] CUR_POS,
    output logic [POS_W-1:0] TGT_POS,
    output logic [15:0] TGT_SPEED,
    output logic [7:0] TGT_ACCEL,
    output logic TGT_PUSH,
    output logic MOVE_REQ,
    output logic MOVE_HALT,
    // position detection to the controller
    output logic START_POS_DETECT,
    output logic END_POS_DETECT,
    output logic MID_POS_DETECT,
    output logic MOVE_ACT_N
);
    import smd_pkg::*;

    // closeness test, shared by the three detectors and the busy flag
    function automatic logic near_pos(input logic [POS_W-1:0] a,
                                      input logic [POS_W-1:0] b,
                                      input logic [15:0] band);
        logic [POS_W-1:0] diff;
        diff = (a >= b) ? (a - b) : (b - a);
        near_pos = ({16'h0, diff} <= {{POS_W{1'b0}}, band});
    endfunction : near_pos

    // destination code to table index; none maps to start, unused then
    function automatic logic [1:0] dst_idx(input smd_dst_t d);
        dst_idx = (d == DST_NONE) ? 2'h0 : (2'(d) - 2'h1);
    endfunction : dst_idx

    // ---------------- pin filtering ----------------
    smd_pin_if #(.N(3)) pins ();

    assign pins.raw = {HOLD_N, MOVE_CMD_SECOND, MOVE_CMD_FIRST};

    smd_pin_sync #(
        .N(3),
        .RST_VAL(`SMD_PIN_RST)
    ) u_pin_sync (
        .clk(CLK),
        .rst_n(RSTN),
        .pins(pins)
    );

    wire st0_c = pins.clean[0];
    wire st1_c = pins.clean[1];
    wire hold_c = pins.clean[2];

    // ---------------- register file ----------------
    smd_pat_t pat_reg;
    smd_pat_t pat_next;
    logic lock_reg;
    logic lock_next;
    logic [POS_W-1:0] pos_reg [0:2];
    logic [`SMD_DATA_W-1:0] prof_reg [0:2];
    logic [15:0] band_reg;
    logic [`SMD_DATA_W-1:0] rdata_reg;

    // address decode
    wire wr_ctrl = REG_WR && (REG_ADDR == `SMD_OFS_CTRL);
    wire wr_band = REG_WR && (REG_ADDR == `SMD_OFS_BAND);
    wire [2:0] wr_pos;
    wire [2:0] wr_prof;
    assign wr_pos[0] = REG_WR && (REG_ADDR == `SMD_OFS_POS_START);
    assign wr_pos[1] = REG_WR && (REG_ADDR == `SMD_OFS_POS_END);
    assign wr_pos[2] = REG_WR && (REG_ADDR == `SMD_OFS_POS_MID);
    assign wr_prof[0] = REG_WR && (REG_ADDR == `SMD_OFS_PROF_START);
    assign wr_prof[1] = REG_WR && (REG_ADDR == `SMD_OFS_PROF_END);
    assign wr_prof[2] = REG_WR && (REG_ADDR == `SMD_OFS_PROF_MID);

    // pattern accepted only until lock; lock clears only with reset
    assign lock_next = lock_reg | (wr_ctrl & REG_WDATA[`SMD_CTRL_LOCK_BIT]);
    assign pat_next = (wr_ctrl && !lock_reg) ?
        smd_pat_t'(REG_WDATA[`SMD_CTRL_PAT_MSB:`SMD_CTRL_PAT_LSB]) : pat_reg; // [R12]

    // control word
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            pat_reg <= PAT_SINGLE;
            lock_reg <= 1'b0;
        end else begin
            pat_reg <= pat_next;
            lock_reg <= lock_next;
        end
    end

    // three target positions and their move profiles
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            for (int i = 0; i < 3; i++) begin
                pos_reg[i] <= '0;
                prof_reg[i] <= `SMD_RST_PROF;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_pos[i]) begin
                    pos_reg[i] <= REG_WDATA[POS_W-1:0]; // [R09] [R10]
                end
                if (wr_prof[i]) begin
                    prof_reg[i] <= REG_WDATA; // [R11]
                end
            end
        end
    end

    // detection window
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            band_reg <= `SMD_RST_BAND;
        end else if (wr_band) begin
            band_reg <= REG_WDATA[15:0];
        end
    end

    // named views for the assertions
    wire [POS_W-1:0] pos_start = pos_reg[0];
    wire [POS_W-1:0] pos_end = pos_reg[1];
    wire [POS_W-1:0] pos_mid = pos_reg[2];
    wire [`SMD_DATA_W-1:0] prof_end = prof_reg[1];

    // ---------------- state ----------------
    smd_state_t state_reg;
    smd_state_t state_next;

    // no motion until configuration is locked; stays running until reset
    always_comb begin
        unique case (state_reg)
            ST_CFG: state_next = lock_reg ? ST_RUN : ST_CFG;
            ST_RUN: state_next = ST_RUN;
            default: state_next = ST_CFG;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state_reg <= ST_CFG;
        end else begin
            state_reg <= state_next;
        end
    end

    wire run = (state_reg == ST_RUN);

    // ---------------- move decoding ----------------
    smd_dst_t dst_reg;
    logic st0_d_reg;
    logic st1_d_reg;
    logic halt_reg;

    // turn-on detection for the double mode
    wire rose0 = st0_c & ~st0_d_reg;
    wire rose1 = st1_c & ~st1_d_reg;
    wire both_on = st0_c & st1_c;
    wire both_off = ~st0_c & ~st1_c;
    wire only0 = st0_c & ~st1_c;
    wire only1 = ~st0_c & st1_c;

    // per-pattern destinations; levels, not pulses, drive most modes
    wire smd_dst_t single_dst = st0_c ? DST_END : DST_START; // [R01] [R02]
    wire smd_dst_t double_dst = (rose1 && !rose0) ? DST_END :    // [R03]
        ((rose0 && !rose1) ? DST_START : dst_reg);               // [R04]
    wire smd_dst_t mid_on_dst = both_on ? DST_MID :              // [R05]
        (only0 ? DST_START : (only1 ? DST_END : dst_reg));
    wire smd_dst_t mid_off_dst = both_off ? DST_MID :            // [R07]
        (only0 ? DST_START : (only1 ? DST_END : dst_reg));

    // halt in place: the unused combination of the three-point mode
    wire pat_halt = ((pat_reg == PAT_MID_ON) && both_off) ||     // [R06]
                    ((pat_reg == PAT_MID_OFF) && both_on);       // [R08]

    wire smd_dst_t dst_sel =
        (pat_reg == PAT_SINGLE) ? single_dst :
        ((pat_reg == PAT_DOUBLE) ? double_dst :
        ((pat_reg == PAT_MID_ON) ? mid_on_dst : mid_off_dst));

    wire smd_dst_t dst_next = run ? dst_sel : DST_NONE;
    wire halt_next = run && (pat_halt || !hold_c); // [R13]
    wire req_next = run && (dst_next != DST_NONE) && !halt_next;

    // target and profile of the chosen destination
    wire [1:0] sel = dst_idx(dst_next);
    wire [POS_W-1:0] pos_sel = pos_reg[sel];
    wire [`SMD_DATA_W-1:0] prof_sel = prof_reg[sel];
    wire arrived = near_pos(CUR_POS, pos_sel, band_reg);

    // detection against each stored target
    wire [2:0] det_next;
    assign det_next[0] = near_pos(CUR_POS, pos_reg[0], band_reg); // [R14]
    assign det_next[1] = near_pos(CUR_POS, pos_reg[1], band_reg); // [R14]
    assign det_next[2] = near_pos(CUR_POS, pos_reg[2], band_reg); // [R14]

    // decoder state and edge history
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            dst_reg <= DST_NONE;
            st0_d_reg <= 1'b0;
            st1_d_reg <= 1'b0;
            halt_reg <= 1'b0;
        end else begin
            dst_reg <= dst_next;
            st0_d_reg <= st0_c;
            st1_d_reg <= st1_c;
            halt_reg <= halt_next;
        end
    end

    // outputs to the motion generator, one cycle after decode
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            TGT_POS <= '0;
            TGT_SPEED <= 16'h0;
            TGT_ACCEL <= 8'h0;
            TGT_PUSH <= 1'b0;
            MOVE_REQ <= 1'b0;
        end else begin
            TGT_POS <= pos_sel; // [R09] [R10]
            TGT_SPEED <= prof_sel[`SMD_PROF_SPD_MSB:`SMD_PROF_SPD_LSB]; // [R11]
            TGT_ACCEL <= prof_sel[`SMD_PROF_ACC_MSB:`SMD_PROF_ACC_LSB]; // [R11]
            TGT_PUSH <= prof_sel[`SMD_PROF_PUSH_BIT]; // [R11]
            MOVE_REQ <= req_next;
        end
    end

    // detection and busy outputs; busy idles high (active low)
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            START_POS_DETECT <= 1'b0;
            END_POS_DETECT <= 1'b0;
            MID_POS_DETECT <= 1'b0;
            MOVE_ACT_N <= 1'b1;
        end else begin
            START_POS_DETECT <= det_next[0];
            END_POS_DETECT <= det_next[1];
            MID_POS_DETECT <= det_next[2];
            MOVE_ACT_N <= !(req_next && !arrived); // [R13]
        end
    end

    assign MOVE_HALT = halt_reg;

    // ---------------- readback ----------------
    wire [`SMD_DATA_W-1:0] ctrl_word = {23'h0, lock_reg, 6'h0, 2'(pat_reg)};
    wire [`SMD_DATA_W-1:0] stat_word = {21'h0, run, det_next,
        2'(dst_reg), MOVE_REQ, halt_reg, hold_c, st1_c, st0_c};
    wire [`SMD_DATA_W-1:0] rd_mux =
        (REG_ADDR == `SMD_OFS_CTRL) ? ctrl_word :
        (REG_ADDR == `SMD_OFS_POS_START) ? `SMD_DATA_W'(pos_reg[0]) :
        (REG_ADDR == `SMD_OFS_POS_END) ? `SMD_DATA_W'(pos_reg[1]) :
        (REG_ADDR == `SMD_OFS_POS_MID) ? `SMD_DATA_W'(pos_reg[2]) :
        (REG_ADDR == `SMD_OFS_PROF_START) ? prof_reg[0] :
        (REG_ADDR == `SMD_OFS_PROF_END) ? prof_reg[1] :
        (REG_ADDR == `SMD_OFS_PROF_MID) ? prof_reg[2] :
        (REG_ADDR == `SMD_OFS_BAND) ? {16'h0, band_reg} :
        (REG_ADDR == `SMD_OFS_STATUS) ? stat_word : 32'h0;

    // read data only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= REG_RD ? rd_mux : 32'h0;
        end
    end

    assign REG_RDATA = rdata_reg;

    // ---------------- checks ----------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    sequence s_single_on;
        run && (pat_reg == PAT_SINGLE) && st0_c;
    endsequence

    sequence s_single_off;
        run && (pat_reg == PAT_SINGLE) && !st0_c;
    endsequence

    sequence s_mid_on_both;
        run && (pat_reg == PAT_MID_ON) && both_on && hold_c;
    endsequence

    sequence s_mid_off_both;
        run && (pat_reg == PAT_MID_OFF) && both_off && hold_c;
    endsequence

    property p_single_end;
        s_single_on |=> (dst_reg == DST_END) && (TGT_POS == $past(pos_end));
    endproperty
    a_single_end: assert property (p_single_end) else $error("single mode missed end"); // [R01]

    property p_single_start;
        s_single_off |=> (dst_reg == DST_START) && (TGT_POS == $past(pos_start));
    endproperty
    a_single_start: assert property (p_single_start) else $error("single mode missed start"); // [R02]

    property p_double_end;
        run && (pat_reg == PAT_DOUBLE) && rose1 && !rose0 |=> dst_reg == DST_END;
    endproperty
    a_double_end: assert property (p_double_end) else $error("double mode missed end"); // [R03]

    property p_double_start;
        run && (pat_reg == PAT_DOUBLE) && rose0 && !rose1 |=> dst_reg == DST_START;
    endproperty
    a_double_start: assert property (p_double_start) else $error("double mode missed start"); // [R04]

    property p_mid_on;
        s_mid_on_both |=> (dst_reg == DST_MID) && !MOVE_HALT && (TGT_POS == $past(pos_mid));
    endproperty
    a_mid_on: assert property (p_mid_on) else $error("both on missed middle"); // [R05]

    property p_mid_on_halt;
        run && (pat_reg == PAT_MID_ON) && both_off |=> MOVE_HALT && !MOVE_REQ;
    endproperty
    a_mid_on_halt: assert property (p_mid_on_halt) else $error("both off did not halt"); // [R06]

    property p_mid_off;
        s_mid_off_both |=> (dst_reg == DST_MID) && MOVE_REQ;
    endproperty
    a_mid_off: assert property (p_mid_off) else $error("both off missed middle"); // [R07]

    property p_mid_off_halt;
        run && (pat_reg == PAT_MID_OFF) && both_on |=> MOVE_HALT && !MOVE_REQ;
    endproperty
    a_mid_off_halt: assert property (p_mid_off_halt) else $error("both on did not halt"); // [R08]

    property p_profile;
        dst_reg == DST_END |-> (TGT_SPEED == $past(prof_end[15:0])) &&
            (TGT_PUSH == $past(prof_end[`SMD_PROF_PUSH_BIT]));
    endproperty
    a_profile: assert property (p_profile) else $error("move profile not applied"); // [R11]

    property p_pat_locked;
        lock_reg && wr_ctrl |=> $stable(pat_reg) && lock_reg;
    endproperty
    a_pat_locked: assert property (p_pat_locked) else $error("pattern changed after lock"); // [R12]

    property p_hold_low;
        run && !hold_c |=> MOVE_HALT && !MOVE_REQ && MOVE_ACT_N;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("low hold input ignored"); // [R13]

    property p_detect;
        det_next[0] && !det_next[1] |=> START_POS_DETECT && !END_POS_DETECT;
    endproperty
    a_detect: assert property (p_detect) else $error("start detect wrong"); // [R14]

endmodule : smd_top

`default_nettype wire

// File: smd_plc_model.sv
`timescale 1ns/1ns
`default_nettype none

// stand-in for the controller pins and the motion generator feedback
module smd_plc_model (
    // clock
    input wire logic clk,
    // levels toward the block
    output logic first,
    output logic second,
    output logic hold_n,
    output logic [15:0] cur_pos
);
    // pins off, hold released, actuator parked away from every target
    initial begin
        first = 1'b0;
        second = 1'b0;
        hold_n = 1'b1;
        cur_pos = 16'h2000;
    end

    // levels move just after an edge and stand until the next call
    task automatic set_pins(input logic f, input logic s, input logic h);
        @(posedge clk);
        first <= f;
        second <= s;
        hold_n <= h;
    endtask : set_pins

    // feedback jumps straight to the given place, no motion profile here
    task automatic set_pos(input logic [15:0] p);
        @(posedge clk);
        cur_pos <= p;
    endtask : set_pos
endmodule : smd_plc_model

`default_nettype wire

// File: tb.sv
`timescale 1ns/1ns
`default_nettype none

`include "smd_params.svh"

`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module tb;
    logic clk, rstn, wr, rd, first, second, hold_n, tgt_push, move_req, move_halt;
    logic start_det, end_det, mid_det, act_n;
    logic [7:0] addr, tgt_accel;
    logic [31:0] wdata, rdata, rd_val;
    logic [15:0] cur_pos, tgt_pos, tgt_speed;
    int error_cnt = 0;
    int total_checks = 0;
    localparam logic [15:0] P_START = 16'h0100;
    localparam logic [15:0] P_END = 16'h0800;
    localparam logic [15:0] P_MID = 16'h0400;
    localparam logic [31:0] F_START = 32'h0020_0100;
    localparam logic [31:0] F_END = 32'h0040_0200;
    localparam logic [31:0] F_MID = 32'h0160_0300;

    // 4 ns clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    smd_top #(.POS_W(16)) dut (.CLK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .MOVE_CMD_FIRST(first),
        .MOVE_CMD_SECOND(second), .HOLD_N(hold_n), .CUR_POS(cur_pos), .TGT_POS(tgt_pos),
        .TGT_SPEED(tgt_speed), .TGT_ACCEL(tgt_accel), .TGT_PUSH(tgt_push),
        .MOVE_REQ(move_req), .MOVE_HALT(move_halt), .START_POS_DETECT(start_det),
        .END_POS_DETECT(end_det), .MID_POS_DETECT(mid_det), .MOVE_ACT_N(act_n));

    smd_plc_model plc (.clk(clk), .first(first), .second(second), .hold_n(hold_n),
        .cur_pos(cur_pos));

    // one-cycle strobes, never overlapping
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    // data stands only in the cycle after the strobe, so sample it there
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd

    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
    endtask : do_reset

    // pin path is about five edges; eight leaves margin
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask : settle

    // pattern is only taken before lock, so every pattern needs a fresh reset
    task automatic cfg(input logic [1:0] pat);
        do_reset();
        reg_wr(`SMD_OFS_POS_START, {16'h0, P_START});
        reg_wr(`SMD_OFS_POS_END, {16'h0, P_END});
        reg_wr(`SMD_OFS_POS_MID, {16'h0, P_MID});
        reg_wr(`SMD_OFS_PROF_START, F_START);
        reg_wr(`SMD_OFS_PROF_END, F_END);
        reg_wr(`SMD_OFS_PROF_MID, F_MID);
        reg_wr(`SMD_OFS_CTRL, {23'h0, 1'b1, 6'h0, pat});
    endtask : cfg

    task automatic check_move(input string nm, input logic [15:0] p, input logic [31:0] f);
        `CHK({nm, " pos"}, p, tgt_pos)
        `CHK({nm, " speed"}, f[15:0], tgt_speed)
        `CHK({nm, " accel"}, f[23:16], tgt_accel)
        `CHK({nm, " push"}, f[24], tgt_push)
        `CHK({nm, " req"}, 1'b1, move_req)
        `CHK({nm, " halt"}, 1'b0, move_halt)
    endtask : check_move

    task automatic check_halt(input string nm);
        `CHK({nm, " req"}, 1'b0, move_req)
        `CHK({nm, " halt"}, 1'b1, move_halt)
    endtask : check_halt

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // a hang past this span counts as a failure
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("watchdog expired");
        tally_and_finish();
    end

    // main sequence
    initial begin
        rstn = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        do_reset();
        #1;
        `CHK("act_n idle", 1'b1, act_n)
        `CHK("req idle", 1'b0, move_req)
        reg_rd(`SMD_OFS_BAND, rd_val);
        `CHK("band reset", 32'h4, rd_val)
        reg_rd(8'hf0, rd_val);
        `CHK("unmapped", 32'h0, rd_val)
        $display("test reset done");

        cfg(`SMD_CODE_SINGLE);
        reg_rd(`SMD_OFS_POS_START, rd_val);
        `CHK("start pos", {16'h0, P_START}, rd_val)
        reg_rd(`SMD_OFS_POS_END, rd_val);
        `CHK("end pos", {16'h0, P_END}, rd_val)
        reg_rd(`SMD_OFS_POS_MID, rd_val);
        `CHK("mid pos", {16'h0, P_MID}, rd_val)
        plc.set_pins(1'b1, 1'b0, 1'b1);
        settle();
        check_move("single on", P_END, F_END);
        `CHK("act_n moving", 1'b0, act_n)
        plc.set_pos(P_END + 16'h4);
        settle();
        `CHK("end det edge", 1'b1, end_det)
        `CHK("start det off", 1'b0, start_det)
        `CHK("act_n arrived", 1'b1, act_n)
        plc.set_pos(P_END + 16'h5);
        settle();
        `CHK("end det out", 1'b0, end_det)
        // a late pattern write must be ignored: double mode would not return
        reg_wr(`SMD_OFS_CTRL, 32'h0000_0101);
        plc.set_pins(1'b0, 1'b0, 1'b1);
        settle();
        check_move("single off", P_START, F_START);
        plc.set_pins(1'b0, 1'b0, 1'b0);
        settle();
        check_halt("hold low");
        $display("test single done");

        cfg(`SMD_CODE_DOUBLE);
        plc.set_pins(1'b0, 1'b1, 1'b1);
        settle();
        check_move("double second", P_END, F_END);
        plc.set_pins(1'b0, 1'b0, 1'b1);
        settle();
        check_move("double release", P_END, F_END);
        plc.set_pins(1'b1, 1'b0, 1'b1);
        settle();
        check_move("double first", P_START, F_START);
        $display("test double done");

        cfg(`SMD_CODE_MID_ON);
        plc.set_pins(1'b1, 1'b1, 1'b1);
        settle();
        check_move("both on mid", P_MID, F_MID);
        plc.set_pos(P_MID);
        settle();
        `CHK("mid det", 1'b1, mid_det)
        plc.set_pins(1'b0, 1'b0, 1'b1);
        settle();
        check_halt("both on halt");
        $display("test mid on done");

        cfg(`SMD_CODE_MID_OFF);
        plc.set_pins(1'b0, 1'b0, 1'b1);
        settle();
        check_move("both off mid", P_MID, F_MID);
        plc.set_pins(1'b1, 1'b1, 1'b1);
        settle();
        check_halt("both off halt");
        $display("test mid off done");
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
